// ==== design/cbtf_core.sv ====
// Bit timing, error detection, fault confinement and interrupt coding
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cbtf_core (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [7:0] reg_rdata_o,
   input wire logic bus_receive_input,
   input wire cbtf_pkg::cbtf_bit_ctx_t bit_ctx_i,
   input wire logic [cbtf_pkg::NUM_IRQ-1:0] irq_event_i,
   output cbtf_pkg::cbtf_err_out_t err_o,
   output logic sample_strobe_o,
   output logic rx_bit_o,
   output logic [2:0] irq_source_code_o,
   output cbtf_pkg::cbtf_fault_state_t fault_state_o
);
   import cbtf_pkg::*;
   localparam int NUM_SRC = 7;

   logic [7:0] bit_timing_prescale_jump;
   logic [7:0] bit_timing_segments_sampling;
   logic [7:0] bit_timing_phase_two;
   logic [1:0] op_mode;
   logic [8:0] receive_fault_count;
   logic [8:0] transmit_fault_count;
   logic fault_warning_flag;
   logic [6:0] irq_flag_reg;
   logic [6:0] irq_enable_reg;
   logic [5:0] comm_status_reg;
   cbtf_fault_state_t fstate;
   logic [7:0] reg_rd_sel;

   // Decoded timing fields
   logic [5:0] quantum_prescale;
   logic [1:0] jump_width_sel;
   logic [2:0] propagation_len;
   logic [2:0] phase_one_len;
   logic triple_sample_sel;
   logic phase_two_source_sel;
   logic [2:0] phase_two_len;
   logic [3:0] prop_tq, ph1_tq, ph2_tq;

   assign quantum_prescale = bit_timing_prescale_jump[PRESC_POS +: 6];
   assign jump_width_sel = bit_timing_prescale_jump[JUMP_POS +: 2];
   assign propagation_len = bit_timing_segments_sampling[PROP_POS +: 3];
   assign phase_one_len = bit_timing_segments_sampling[PH1_POS +: 3];
   assign triple_sample_sel = bit_timing_segments_sampling[TRIPLE_POS];
   assign phase_two_source_sel = bit_timing_segments_sampling[PH2SRC_POS];
   assign phase_two_len = bit_timing_phase_two[PH2_POS +: 3];
   assign prop_tq = {1'b0, propagation_len} + 4'h1;
   assign ph1_tq = {1'b0, phase_one_len} + 4'h1;

   // Phase two field matters only when its source select is set
   always_comb begin
      if (phase_two_source_sel) begin
         ph2_tq = {1'b0, phase_two_len} + 4'h1;
      end else if (ph1_tq > IPT_TQ) begin
         ph2_tq = ph1_tq;
      end else begin
         ph2_tq = IPT_TQ;
      end
   end

   // Register writes; timing only in configuration mode
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         bit_timing_prescale_jump <= TIMING1_RESET;
         bit_timing_segments_sampling <= TIMING2_RESET;
         bit_timing_phase_two <= TIMING3_RESET;
         op_mode <= MODE_RESET;
         irq_enable_reg <= 7'h00;
      end else if (reg_write_i) begin
         case (reg_addr_i)
            REG_TIMING1: if (op_mode == MODE_CONFIG) begin
               bit_timing_prescale_jump <= reg_wdata_i;
            end
            REG_TIMING2: if (op_mode == MODE_CONFIG) begin
               bit_timing_segments_sampling <= reg_wdata_i;
            end
            REG_TIMING3: if (op_mode == MODE_CONFIG) begin
               bit_timing_phase_two <= reg_wdata_i;
            end
            REG_MODE: op_mode <= reg_wdata_i[1:0];
            REG_IRQ_ENABLE: irq_enable_reg <= reg_wdata_i[6:0];
            default: ;
         endcase
      end
   end

   // Quantum: prescale of value+1, then fixed divide by two
   logic [6:0] presc_cnt;
   logic half_tick, tq_tick, half_phase;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         presc_cnt <= 7'h00;
         half_phase <= 1'b0;
      end else if (presc_cnt == {1'b0, quantum_prescale}) begin
         presc_cnt <= 7'h00;
         half_phase <= ~half_phase;
      end else begin
         presc_cnt <= presc_cnt + 7'h01;
      end
   end
   // One half-quantum per prescale wrap; a quantum is two halves
   assign half_tick = presc_cnt == {1'b0, quantum_prescale};
   assign tq_tick = half_tick & half_phase;

   // Bit segment counter; resync edge logic lives elsewhere, the
   // jump width is only decoded to a quanta count of value+1
   cbtf_seg_t seg;
   logic [3:0] seg_cnt;
   logic [2:0] jump_tq;
   assign jump_tq = {1'b0, jump_width_sel} + 3'h1;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         seg <= CBTF_SEG_SYNC;
         seg_cnt <= 4'h0;
      end else if (tq_tick) begin
         case (seg)
            CBTF_SEG_SYNC: begin
               seg <= CBTF_SEG_PROP;
               seg_cnt <= 4'h1;
            end
            CBTF_SEG_PROP: if (seg_cnt == prop_tq) begin
               seg <= CBTF_SEG_PH1;
               seg_cnt <= 4'h1;
            end else begin
               seg_cnt <= seg_cnt + 4'h1;
            end
            CBTF_SEG_PH1: if (seg_cnt == ph1_tq) begin
               seg <= CBTF_SEG_PH2;
               seg_cnt <= 4'h1;
            end else begin
               seg_cnt <= seg_cnt + 4'h1;
            end
            CBTF_SEG_PH2: if (seg_cnt == ph2_tq) begin
               seg <= CBTF_SEG_SYNC;
               seg_cnt <= 4'h0;
            end else begin
               seg_cnt <= seg_cnt + 4'h1;
            end
            default: seg <= CBTF_SEG_SYNC;
         endcase
      end
   end

   // Sample point is the quantum edge ending phase one
   logic sample_pt;
   assign sample_pt = tq_tick & (seg == CBTF_SEG_PH1) &
      (seg_cnt == ph1_tq);
   // Early samples: one and two half-quanta before the sample point.
   // Shifting on every half-quantum keeps the spacing right even when
   // phase one is one quantum and the first sample falls in prop.
   logic [1:0] early;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         early <= 2'h3;
      end else if (half_tick) begin
         early <= {early[0], bus_receive_input};
      end
   end
   logic maj, rx_now;
   assign maj = (early[0] & early[1]) | (early[0] & bus_receive_input) |
      (early[1] & bus_receive_input);
   assign rx_now = triple_sample_sel ? maj : bus_receive_input;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sample_strobe_o <= 1'b0;
         rx_bit_o <= 1'b1;
      end else begin
         sample_strobe_o <= sample_pt;
         if (sample_pt) begin
            rx_bit_o <= rx_now;
         end
      end
   end

   // Error detection per received bit (1 = recessive)
   logic [2:0] run_len;
   logic run_val;
   logic e_crc, e_ack, e_form, e_bit, e_stuff, any_err;
   logic stuff_hit;
   assign stuff_hit = bit_ctx_i.in_stuff_region & (rx_now == run_val) &
      (run_len == STUFF_LIMIT - 3'h1);
   always_comb begin
      e_crc = bit_ctx_i.crc_mismatch;
      e_ack = bit_ctx_i.transmitting & bit_ctx_i.in_ack_slot & rx_now;
      e_form = bit_ctx_i.in_fixed_form & ~rx_now;
      e_bit = bit_ctx_i.transmitting & (bit_ctx_i.sent_bit != rx_now) &
         ~(bit_ctx_i.sent_bit & ~rx_now &
         (bit_ctx_i.in_arbitration | bit_ctx_i.in_ack_slot));
      e_stuff = stuff_hit;
      any_err = bit_ctx_i.valid & (fstate != CBTF_BUS_OFF) &
         (e_crc | e_ack | e_form | e_bit | e_stuff);
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         run_len <= 3'h0;
         run_val <= 1'b1;
      end else if (sample_pt & bit_ctx_i.valid) begin
         if (!bit_ctx_i.in_stuff_region || rx_now != run_val) begin
            run_len <= 3'h1;
            run_val <= rx_now;
         end else if (run_len != STUFF_LIMIT) begin
            run_len <= run_len + 3'h1;
         end
      end
   end

   // Fault confinement counters
   logic [3:0] rec_run;
   logic [7:0] rec_seq;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         receive_fault_count <= 9'h000;
         transmit_fault_count <= 9'h000;
         rec_run <= 4'h0;
         rec_seq <= 8'h00;
      end else if (sample_pt) begin
         if (fstate == CBTF_BUS_OFF) begin
            if (!rx_now) begin
               rec_run <= 4'h0;
            end else if (rec_run == RECESSIVE_RUN - 4'h1) begin
               rec_run <= 4'h0;
               if (rec_seq == RECOVERY_COUNT - 8'h01) begin
                  rec_seq <= 8'h00;
                  receive_fault_count <= 9'h000;
                  transmit_fault_count <= 9'h000;
               end else begin
                  rec_seq <= rec_seq + 8'h01;
               end
            end else begin
               rec_run <= rec_run + 4'h1;
            end
         end else if (any_err && bit_ctx_i.transmitting) begin
            transmit_fault_count <= transmit_fault_count + TX_ERR_STEP;
         end else if (any_err) begin
            if (receive_fault_count < BUSOFF_LIMIT - 9'h001) begin
               receive_fault_count <= receive_fault_count + RX_ERR_STEP;
            end
         end else if (bit_ctx_i.valid && bit_ctx_i.tx_ok &&
                      transmit_fault_count != 9'h000) begin
            transmit_fault_count <= transmit_fault_count - 9'h001;
         end else if (bit_ctx_i.valid && bit_ctx_i.rx_ok &&
                      receive_fault_count != 9'h000) begin
            receive_fault_count <= receive_fault_count - 9'h001;
         end
      end
   end

   // Fault state derives from the counters
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         fstate <= CBTF_ERR_ACTIVE;
         fault_warning_flag <= 1'b0;
      end else begin
         if (transmit_fault_count >= BUSOFF_LIMIT) begin
            fstate <= CBTF_BUS_OFF;
         end else if (receive_fault_count >= PASSIVE_LIMIT ||
                      transmit_fault_count >= PASSIVE_LIMIT) begin
            fstate <= CBTF_ERR_PASSIVE;
         end else begin
            fstate <= CBTF_ERR_ACTIVE;
         end
         fault_warning_flag <= (receive_fault_count >= WARN_LIMIT) |
            (transmit_fault_count >= WARN_LIMIT);
      end
   end

   // Status bits: rx warn, tx warn, rx passive, tx passive, bus-off, warn
   logic [5:0] next_comm;
   assign next_comm = {fault_warning_flag, fstate == CBTF_BUS_OFF,
      transmit_fault_count >= PASSIVE_LIMIT,
      receive_fault_count >= PASSIVE_LIMIT,
      transmit_fault_count >= WARN_LIMIT,
      receive_fault_count >= WARN_LIMIT};
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         comm_status_reg <= 6'h00;
      end else begin
         comm_status_reg <= next_comm;
      end
   end

   // Flags: hardware set wins over a software clear in the same cycle
   logic [6:0] flag_set;
   assign flag_set = {irq_event_i[6:1],
      irq_event_i[0] | (next_comm != comm_status_reg) | any_err};
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
         always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
               irq_flag_reg[gi] <= 1'b0;
            end else if (flag_set[gi]) begin
               irq_flag_reg[gi] <= 1'b1;
            end else if (reg_write_i && reg_addr_i == REG_IRQ_FLAG &&
                         !reg_wdata_i[gi]) begin
               irq_flag_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Lowest index wins; code is index plus one
   logic [6:0] pend;
   logic [2:0] next_code;
   assign pend = irq_flag_reg & irq_enable_reg;
   always_comb begin
      next_code = 3'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            next_code = 3'(i + 1);
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         irq_source_code_o <= 3'h0;
         fault_state_o <= CBTF_ERR_ACTIVE;
         err_o <= '0;
      end else begin
         irq_source_code_o <= next_code;
         fault_state_o <= fstate;
         err_o.abort_retry <= sample_pt & any_err;
         err_o.error_frame <= sample_pt & any_err;
         err_o.error_dominant <= fstate == CBTF_ERR_ACTIVE;
         err_o.bus_blocked <= fstate == CBTF_BUS_OFF;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      case (reg_addr_i)
         REG_TIMING1: reg_rd_sel = bit_timing_prescale_jump;
         REG_TIMING2: reg_rd_sel = bit_timing_segments_sampling;
         REG_TIMING3: reg_rd_sel = bit_timing_phase_two;
         REG_MODE: reg_rd_sel = {6'h00, op_mode};
         REG_RX_COUNT: reg_rd_sel = receive_fault_count[8] ? 8'hff :
            receive_fault_count[7:0];
         REG_TX_COUNT: reg_rd_sel = transmit_fault_count[8] ? 8'hff :
            transmit_fault_count[7:0];
         REG_COMM_STATUS: reg_rd_sel = {2'h0, comm_status_reg};
         REG_IRQ_FLAG: reg_rd_sel = {1'b0, irq_flag_reg};
         REG_IRQ_ENABLE: reg_rd_sel = {1'b0, irq_enable_reg};
         REG_CTRL_STATUS: reg_rd_sel = {2'h0, fstate, 1'b0,
            irq_source_code_o};
         default: reg_rd_sel = 8'h00;
      endcase
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_read_i) begin
         reg_rdata_o <= reg_rd_sel;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ==== pkg/cbtf_pkg.sv ====
// Package for the CAN bit timing, fault confinement and interrupt block
package cbtf_pkg;
   localparam logic [3:0] REG_TIMING1 = 4'h0;
   localparam logic [3:0] REG_TIMING2 = 4'h1;
   localparam logic [3:0] REG_TIMING3 = 4'h2;
   localparam logic [3:0] REG_MODE = 4'h3;
   localparam logic [3:0] REG_RX_COUNT = 4'h4;
   localparam logic [3:0] REG_TX_COUNT = 4'h5;
   localparam logic [3:0] REG_COMM_STATUS = 4'h6;
   localparam logic [3:0] REG_IRQ_FLAG = 4'h7;
   localparam logic [3:0] REG_IRQ_ENABLE = 4'h8;
   localparam logic [3:0] REG_CTRL_STATUS = 4'h9;
   localparam logic [7:0] TIMING1_RESET = 8'h00;
   localparam logic [7:0] TIMING2_RESET = 8'h00;
   localparam logic [7:0] TIMING3_RESET = 8'h00;
   localparam logic [1:0] MODE_CONFIG = 2'h1;
   localparam logic [1:0] MODE_RESET = 2'h1;
   localparam int PRESC_POS = 0;
   localparam int JUMP_POS = 6;
   localparam int PROP_POS = 0;
   localparam int PH1_POS = 3;
   localparam int TRIPLE_POS = 6;
   localparam int PH2SRC_POS = 7;
   localparam int PH2_POS = 0;
   localparam logic [3:0] IPT_TQ = 4'h2;
   localparam logic [8:0] WARN_LIMIT = 9'h060;
   localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
   localparam logic [8:0] BUSOFF_LIMIT = 9'h100;
   localparam logic [7:0] RECOVERY_COUNT = 8'h80;
   localparam logic [3:0] RECESSIVE_RUN = 4'hb;
   localparam logic [2:0] STUFF_LIMIT = 3'h6;
   localparam logic [8:0] TX_ERR_STEP = 9'h008;
   localparam logic [8:0] RX_ERR_STEP = 9'h001;
   localparam int IRQ_ERR = 0;
   localparam int IRQ_WAKE = 1;
   localparam int IRQ_TX0 = 2;
   localparam int IRQ_RX0 = 5;
   localparam int NUM_IRQ = 7;
   typedef enum logic [1:0] {
      CBTF_ERR_ACTIVE,
      CBTF_ERR_PASSIVE,
      CBTF_BUS_OFF
   } cbtf_fault_state_t;
   typedef enum logic [2:0] {
      CBTF_SEG_SYNC,
      CBTF_SEG_PROP,
      CBTF_SEG_PH1,
      CBTF_SEG_PH2
   } cbtf_seg_t;
   // Per-bit frame context supplied by the frame engine
   typedef struct packed {
      logic valid;
      logic transmitting;
      logic sent_bit;
      logic in_arbitration;
      logic in_ack_slot;
      logic in_fixed_form;
      logic in_stuff_region;
      logic crc_mismatch;
      logic rx_ok;
      logic tx_ok;
   } cbtf_bit_ctx_t;
   // Per-bit answer to the frame engine
   typedef struct packed {
      logic abort_retry;
      logic error_frame;
      logic error_dominant;
      logic bus_blocked;
   } cbtf_err_out_t;
endpackage

// ==== verification/cbtf_core_assertions.sv ====
// Concurrent checks on the CAN timing, fault and interrupt core
`timescale 1ns/1ns
`default_nettype none
module cbtf_core_checker
   import cbtf_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [7:0] reg_rdata_o,
   input wire cbtf_pkg::cbtf_bit_ctx_t bit_ctx_i,
   input wire cbtf_pkg::cbtf_err_out_t err_o,
   input wire logic sample_strobe_o,
   input wire logic rx_bit_o,
   input wire cbtf_pkg::cbtf_fault_state_t fault_state_o
);
   logic cfg_q;
   logic blk_q;
   cbtf_bit_ctx_t ctx_q;
   logic [7:0] tim_q [3];
   logic [7:0] exp_q;
   // Shadow of the mode so timing writes outside it can be judged
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) cfg_q <= 1'b1;
      else if (reg_write_i && reg_addr_i == REG_MODE)
         cfg_q <= reg_wdata_i[1:0] == MODE_CONFIG;
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         tim_q <= '{TIMING1_RESET, TIMING2_RESET, TIMING3_RESET};
      end else if (reg_write_i && cfg_q && reg_addr_i < REG_MODE) begin
         tim_q[reg_addr_i[1:0]] <= reg_wdata_i;
      end
   end
   always_ff @(posedge clock_i) exp_q <= tim_q[reg_addr_i[1:0]];
   // Context as it stood at the sample point, one cycle before the strobe
   always_ff @(posedge clock_i) ctx_q <= bit_ctx_i;
   always_ff @(posedge clock_i) blk_q <= err_o.bus_blocked;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_live;
      sample_strobe_o && ctx_q.valid && !blk_q;
   endsequence
   sequence s_flagged;
      err_o.error_frame && err_o.abort_retry;
   endsequence
   chk_rdata_idle: assert property (
      !$past(reg_read_i) |-> reg_rdata_o == 8'h00)
      else $error("read data not idle");
   chk_unmapped_zero: assert property (
      reg_read_i && reg_addr_i > REG_CTRL_STATUS |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_timing_lock: assert property (
      reg_read_i && reg_addr_i < REG_MODE |=> reg_rdata_o == exp_q)
      else $error("timing register wrong");
   chk_abort_pair: assert property (
      err_o.abort_retry == err_o.error_frame)
      else $error("abort and error frame differ");
   chk_error_at_sample: assert property (
      err_o.error_frame |-> sample_strobe_o)
      else $error("error away from sample point");
   chk_crc_error: assert property (
      s_live ##0 ctx_q.crc_mismatch |-> s_flagged)
      else $error("crc error missed");
   chk_ack_error: assert property (
      s_live ##0 ctx_q.transmitting && ctx_q.in_ack_slot && rx_bit_o
      |-> s_flagged)
      else $error("ack error missed");
   chk_form_error: assert property (
      s_live ##0 ctx_q.in_fixed_form && !rx_bit_o |-> s_flagged)
      else $error("form error missed");
   chk_bit_error: assert property (
      s_live ##0 ctx_q.transmitting && ctx_q.sent_bit != rx_bit_o
      && !(ctx_q.sent_bit && (ctx_q.in_arbitration || ctx_q.in_ack_slot))
      |-> s_flagged)
      else $error("bit error missed");
   chk_passive_recessive: assert property (
      fault_state_o != CBTF_ERR_ACTIVE && $past(fault_state_o) !=
      CBTF_ERR_ACTIVE |-> !err_o.error_dominant)
      else $error("dominant error frame while passive");
   chk_busoff_silent: assert property (
      $stable(fault_state_o) && fault_state_o == CBTF_BUS_OFF
      |-> err_o.bus_blocked && !err_o.error_frame)
      else $error("bus-off node not silent");
   chk_strobe_gap: assert property (
      sample_strobe_o |=> !sample_strobe_o [*5])
      else $error("sample points too close");
endmodule
bind cbtf_core cbtf_core_checker cbtf_core_checker_i (
   .clock_i(clock_i),
   .sys_rst_i(sys_rst_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_write_i(reg_write_i),
   .reg_read_i(reg_read_i),
   .reg_rdata_o(reg_rdata_o),
   .bit_ctx_i(bit_ctx_i),
   .err_o(err_o),
   .sample_strobe_o(sample_strobe_o),
   .rx_bit_o(rx_bit_o),
   .fault_state_o(fault_state_o)
);
`default_nettype wire

// ==== verification/cbtf_bus_nodes.sv ====
// Other nodes on the shared bus, seen as one wired level
`timescale 1ns/1ns
`default_nettype none
module cbtf_bus_nodes (
   input wire logic [1:0] node_drive_i,
   output logic bus_o
);
   // Recessive pull-up: any dominant node wins the wire
   assign bus_o = &node_drive_i;
endmodule
`default_nettype wire

// ==== verification/cbtf_core_test.sv ====
// Self-checking bench for the CAN timing, fault and interrupt core
`timescale 1ns/1ns
`default_nettype none
module cbtf_core_test;
   import cbtf_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_write_i = 1'b0;
   logic reg_read_i = 1'b0;
   logic [1:0] drive = 2'h3;
   logic [6:0] irq_event_i = 7'h00;
   cbtf_bit_ctx_t bit_ctx_i = '0;
   logic [7:0] reg_rdata_o;
   logic bus_rx;
   cbtf_err_out_t err_o;
   logic sample_strobe_o;
   logic rx_bit_o;
   logic [2:0] irq_source_code_o;
   cbtf_fault_state_t fault_state_o;
   logic [15:0] per;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   // Rows of {timing1, timing2, timing3}, all keeping prop+ph1>=ph2>=jump
   logic [23:0] cfg [4] = '{24'h000007, 24'h013a00, 24'h40c902,
      24'h3f0000};
   // Rows of {context, bus level, error expected}
   logic [11:0] tbl [10] = '{12'h813, 12'he83, 12'he80, 12'h841,
      12'h842, 12'hc03, 12'hf00, 12'he01, 12'h80a, 12'h806};
   cbtf_bus_nodes cbtf_bus_nodes_i (.node_drive_i(drive), .bus_o(bus_rx));
   cbtf_core cbtf_core_i (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i),
      .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o),
      .bus_receive_input(bus_rx),
      .bit_ctx_i(bit_ctx_i),
      .irq_event_i(irq_event_i),
      .err_o(err_o),
      .sample_strobe_o(sample_strobe_o),
      .rx_bit_o(rx_bit_o),
      .irq_source_code_o(irq_source_code_o),
      .fault_state_o(fault_state_o)
   );
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   task automatic results;
      if (errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         errors++;
         $display("Error at %0t: run hung", $time);
         results;
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_reset;
      sys_rst_i <= 1'b1;
      repeat (10) @(posedge clock_i);
      sys_rst_i <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clock_i);
      reg_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      @(posedge clock_i);
      d = reg_rdata_o;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      check({8'h00, d}, {8'h00, e});
   endtask
   // Returns on the edge where a strobe is seen; per holds the spacing
   task automatic strobe;
      per = 16'h0000;
      do begin
         @(posedge clock_i);
         per++;
      end while (sample_strobe_o !== 1'b1 && per < 16'd2000);
   endtask
   function automatic logic [15:0] bit_clocks(input logic [23:0] c);
      logic [15:0] q;
      logic [15:0] p1;
      logic [15:0] p2;
      q = 16'h0002 * ({10'h000, c[21:16]} + 16'h0001);
      p1 = {13'h0000, c[13:11]} + 16'h0001;
      p2 = (p1 > 16'h0002) ? p1 : 16'h0002;
      if (c[15]) p2 = {13'h0000, c[2:0]} + 16'h0001;
      return q * (16'h0002 + {13'h0000, c[10:8]} + p1 + p2);
   endfunction
   // Dominant pulse of n cycles ending on the next sample point
   task automatic glitch(input int n, input logic e);
      strobe;
      repeat (9 - n) @(posedge clock_i);
      drive <= 2'h2;
      repeat (n) @(posedge clock_i);
      drive <= 2'h3;
      strobe;
      check({15'h0000, rx_bit_o}, {15'h0000, e});
   endtask
   task automatic bit_ck(input cbtf_bit_ctx_t c, input logic l,
      input logic e);
      strobe;
      bit_ctx_i <= c;
      drive <= {1'b1, l};
      strobe;
      bit_ctx_i <= '0;
      check({14'h0000, err_o.abort_retry, err_o.error_frame}, {14'h0000, e, e});
   endtask
   task automatic burst(input int n);
      strobe;
      bit_ctx_i <= cbtf_bit_ctx_t'(10'h300);
      repeat (n) strobe;
      bit_ctx_i <= '0;
   endtask
   task automatic pulse(input logic [6:0] v);
      @(posedge clock_i);
      irq_event_i <= v;
      @(posedge clock_i);
      irq_event_i <= 7'h00;
   endtask
   initial begin
      logic [7:0] d;
      do_reset;
      rc(REG_TIMING1, TIMING1_RESET);
      rc(REG_TIMING2, TIMING2_RESET);
      rc(REG_MODE, {6'h00, MODE_RESET});
      rc(4'hf, 8'h00);
      foreach (cfg[i]) begin
         wr(REG_TIMING1, cfg[i][23:16]);
         wr(REG_TIMING2, cfg[i][15:8]);
         wr(REG_TIMING3, cfg[i][7:0]);
         rc(REG_TIMING1, cfg[i][23:16]);
         rc(REG_TIMING2, cfg[i][15:8]);
         repeat (3) strobe;
         check(per, bit_clocks(cfg[i]));
      end
      wr(REG_MODE, 8'h00);
      wr(REG_TIMING1, 8'h55);
      rc(REG_TIMING1, 8'h3f);
      wr(REG_MODE, 8'h01);
      wr(REG_TIMING1, 8'h00);
      rc(REG_TIMING1, 8'h00);
      wr(REG_MODE, 8'h00);
      glitch(1, 1'b0);
      wr(REG_MODE, 8'h01);
      wr(REG_TIMING2, 8'h40);
      wr(REG_MODE, 8'h00);
      glitch(1, 1'b1);
      glitch(2, 1'b0);
      foreach (tbl[i]) bit_ck(tbl[i][11:2], tbl[i][1], tbl[i][0]);
      strobe;
      bit_ctx_i <= cbtf_bit_ctx_t'(10'h208);
      drive <= 2'h3;
      strobe;
      drive <= 2'h2;
      for (int k = 1; k <= 6; k++) begin
         strobe;
         check({15'h0000, err_o.error_frame}, {15'h0000, k == 6});
      end
      bit_ctx_i <= '0;
      drive <= 2'h3;
      rc(REG_RX_COUNT, 8'h02);
      rc(REG_TX_COUNT, 8'h17);
      check({15'h0000, err_o.error_dominant}, 16'h0001);
      do_reset;
      wr(REG_MODE, 8'h00);
      burst(12);
      rc(REG_TX_COUNT, 8'h60);
      rd(REG_COMM_STATUS, d);
      check({8'h00, d & 8'h3a}, 16'h0022);
      burst(4);
      rd(REG_COMM_STATUS, d);
      check({8'h00, d & 8'h3a}, 16'h002a);
      check({14'h0000, fault_state_o}, {14'h0000, CBTF_ERR_PASSIVE});
      check({15'h0000, err_o.error_dominant}, 16'h0000);
      burst(16);
      rc(REG_TX_COUNT, 8'hff);
      check({14'h0000, fault_state_o}, {14'h0000, CBTF_BUS_OFF});
      burst(1);
      check({14'h0000, err_o.bus_blocked, err_o.error_frame}, 16'h0002);
      repeat (14000) @(posedge clock_i);
      check({14'h0000, fault_state_o}, {14'h0000, CBTF_BUS_OFF});
      for (int w = 0; w < 400 && fault_state_o != CBTF_ERR_ACTIVE; w++)
         @(posedge clock_i);
      check({14'h0000, fault_state_o}, {14'h0000, CBTF_ERR_ACTIVE});
      rc(REG_TX_COUNT, 8'h00);
      wr(REG_IRQ_FLAG, 8'h00);
      wr(REG_IRQ_ENABLE, 8'h7f);
      rc(REG_IRQ_ENABLE, 8'h7f);
      pulse(7'h7f);
      for (int i = 0; i < 8; i++) begin
         rd(REG_CTRL_STATUS, d);
         check({13'h0000, d[2:0]}, {13'h0000, 3'(i + 1)});
         check({13'h0000, irq_source_code_o}, {13'h0000, 3'(i + 1)});
         wr(REG_IRQ_FLAG, (8'h7f << (i + 1)) & 8'h7f);
      end
      wr(REG_IRQ_ENABLE, 8'h02);
      pulse(7'h03);
      rc(REG_CTRL_STATUS, 8'h02);
      wr(REG_IRQ_ENABLE, 8'h00);
      rc(REG_CTRL_STATUS, 8'h00);
      results;
   end
endmodule
`default_nettype wire
